/* include/cvlc_pkg.sv */
// Package for the coil voltage limit check: offsets, fields, reset values
`default_nettype none
package cvlc_pkg;
  localparam int unsigned       CVLC_ADDR_W       = 7;
  localparam int unsigned       CVLC_DATA_W       = 16;
  localparam int unsigned       CVLC_THR_W        = 10;
  localparam logic [6:0]        CVLC_OFS_LOWER_A  = 7'h0E;
  localparam logic [6:0]        CVLC_OFS_UPPER    = 7'h0F;
  localparam int unsigned       CVLC_THR_LSB      = 1;
  localparam int unsigned       CVLC_THR_MSB      = 10;
  localparam int unsigned       CVLC_PARITY_BIT   = 0;
  localparam logic [9:0]        CVLC_LOWER_A_RST  = 10'h000;
  localparam logic [9:0]        CVLC_UPPER_RST    = 10'h3FF;
  localparam logic [15:0]       CVLC_UNMAPPED_RD  = 16'h0000;
endpackage
`default_nettype wire

/* logic/cvlc_top.sv */
// Coil voltage window comparator with its two threshold registers
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Lower threshold A at 0x0E, bits 10:1, reset zero, reserved read zero.
// - On each new measurement, below-lower-A flag = measurement below threshold A.
// - Upper threshold at 0x0F, bits 10:1, reset all ones, reserved read zero.
// - On each new measurement, above-upper flag = measurement above upper threshold.
// - Thresholds are ten-bit unsigned, compared directly with the measurement.
// - Measurement is the averaged ten-bit value at phase counter 48.
module cvlc_top
  import cvlc_pkg::*;
(
  input  wire logic                             mclk,                  // System clock
  input  wire logic                             rst_b,                 // Async reset, active low
  input  wire logic                             reg_wr,                // Register write strobe
  input  wire logic [cvlc_pkg::CVLC_ADDR_W-1:0] reg_addr,              // Register offset
  input  wire logic [cvlc_pkg::CVLC_DATA_W-1:0] reg_wdata,             // Write frame word
  output logic      [cvlc_pkg::CVLC_DATA_W-1:0] reg_rdata,             // Read word, parity zero
  input  wire logic                             meas_valid,            // New measurement pulse
  input  wire logic [cvlc_pkg::CVLC_THR_W-1:0]  measured_coil_voltage, // Averaged value
  output logic                                  below_lower_a_flag,    // Below threshold A
  output logic                                  above_upper_flag       // Above upper threshold
);
  import cvlc_pkg::*;

  // ------------------------------------------------------------
  // Threshold registers
  // ------------------------------------------------------------
  logic [9:0] lower_threshold_a_q;
  logic [9:0] upper_threshold_q;
  logic       wr_lower_a;
  logic       wr_upper;

  // Offset match, shared by the write enables
  function automatic logic cvlc_hit(input logic [CVLC_ADDR_W-1:0] addr,
                                    input logic [CVLC_ADDR_W-1:0] ofs);
    cvlc_hit = (addr == ofs);
  endfunction

  function automatic logic [15:0] cvlc_pack(input logic [9:0] thr);
    cvlc_pack = {5'h00, thr, 1'b0};
  endfunction

  // Writes to any other offset are dropped, so a frame aimed at a
  // neighbour register can never disturb a threshold
  assign wr_lower_a = reg_wr && cvlc_hit(reg_addr, CVLC_OFS_LOWER_A);
  assign wr_upper   = reg_wr && cvlc_hit(reg_addr, CVLC_OFS_UPPER);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lower_threshold_a_q <= CVLC_LOWER_A_RST;
    end else if (wr_lower_a) begin
      lower_threshold_a_q <= reg_wdata[CVLC_THR_MSB:CVLC_THR_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      upper_threshold_q <= CVLC_UPPER_RST;
    end else if (wr_upper) begin
      upper_threshold_q <= reg_wdata[CVLC_THR_MSB:CVLC_THR_LSB];
    end
  end

  // Write path checks
  lower_wr_take_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wr_lower_a
    |=> lower_threshold_a_q == $past(reg_wdata[CVLC_THR_MSB:CVLC_THR_LSB])
  ) else $error("lower threshold write not taken");

  upper_wr_take_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wr_upper
    |=> upper_threshold_q == $past(reg_wdata[CVLC_THR_MSB:CVLC_THR_LSB])
  ) else $error("upper threshold write not taken");

  lower_keep_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !wr_lower_a
    |=> $stable(lower_threshold_a_q)
  ) else $error("lower threshold changed without a write");

  upper_keep_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !wr_upper
    |=> $stable(upper_threshold_q)
  ) else $error("upper threshold changed without a write");

  thr_reset_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(rst_b)
    |-> lower_threshold_a_q == CVLC_LOWER_A_RST && upper_threshold_q == CVLC_UPPER_RST
  ) else $error("threshold reset value wrong");

  // Read path registered; parity is added by the frame logic outside
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= CVLC_UNMAPPED_RD;
    end else begin
      case (reg_addr)
        CVLC_OFS_LOWER_A: reg_rdata <= cvlc_pack(lower_threshold_a_q);
        CVLC_OFS_UPPER:   reg_rdata <= cvlc_pack(upper_threshold_q);
        default:          reg_rdata <= CVLC_UNMAPPED_RD;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Window comparison
  // ------------------------------------------------------------
  // Flags hold between measurements, so a late threshold write only
  // takes effect at the next measurement
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      below_lower_a_flag <= 1'b0;
      above_upper_flag   <= 1'b0;
    end else if (meas_valid) begin
      below_lower_a_flag <= measured_coil_voltage < lower_threshold_a_q;
      above_upper_flag   <= measured_coil_voltage > upper_threshold_q;
    end
  end

  // ------------------------------------------------------------
  // Check helpers
  // ------------------------------------------------------------
  // Inputs of the last comparison, kept only for the checks, so the
  // flags can be held to them long after the measurement
  logic [CVLC_THR_W-1:0] chk_meas_q;
  logic [CVLC_THR_W-1:0] chk_lower_q;
  logic [CVLC_THR_W-1:0] chk_upper_q;
  logic                  chk_seen_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      chk_meas_q  <= 10'h000;
      chk_lower_q <= CVLC_LOWER_A_RST;
      chk_upper_q <= CVLC_UPPER_RST;
      chk_seen_q  <= 1'b0;
    end else if (meas_valid) begin
      chk_meas_q  <= measured_coil_voltage;
      chk_lower_q <= lower_threshold_a_q;
      chk_upper_q <= upper_threshold_q;
      chk_seen_q  <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  lower_flag_set_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    meas_valid
    |=> below_lower_a_flag == ($past(measured_coil_voltage) < $past(lower_threshold_a_q))
  ) else $error("lower flag wrong after measurement");

  upper_flag_set_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    meas_valid
    |=> above_upper_flag == ($past(measured_coil_voltage) > $past(upper_threshold_q))
  ) else $error("upper flag wrong after measurement");

  lower_flag_clr_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    meas_valid && measured_coil_voltage >= lower_threshold_a_q
    |=> !below_lower_a_flag
  ) else $error("lower flag not cleared");

  upper_flag_clr_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    meas_valid && measured_coil_voltage <= upper_threshold_q
    |=> !above_upper_flag
  ) else $error("upper flag not cleared");

  flags_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !meas_valid
    |=> $stable(below_lower_a_flag) && $stable(above_upper_flag)
  ) else $error("flag changed without measurement");

  flags_reset_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(rst_b)
    |-> !below_lower_a_flag && !above_upper_flag
  ) else $error("flags not clear after reset");

  flags_track_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    chk_seen_q
    |-> below_lower_a_flag == (chk_meas_q < chk_lower_q)
        && above_upper_flag == (chk_meas_q > chk_upper_q)
  ) else $error("flags no longer match last measurement");

  lower_reg_rd_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reg_wr && reg_addr == CVLC_OFS_LOWER_A ##1 reg_addr == CVLC_OFS_LOWER_A && !reg_wr
    |=> reg_rdata == {5'h00, $past(reg_wdata[CVLC_THR_MSB:CVLC_THR_LSB], 2), 1'b0}
  ) else $error("lower threshold readback wrong");

  upper_reg_rd_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reg_wr && reg_addr == CVLC_OFS_UPPER ##1 reg_addr == CVLC_OFS_UPPER && !reg_wr
    |=> reg_rdata == {5'h00, $past(reg_wdata[CVLC_THR_MSB:CVLC_THR_LSB], 2), 1'b0}
  ) else $error("upper threshold readback wrong");

  reserved_zero_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1
    |-> reg_rdata[15:11] == 5'h00 && reg_rdata[CVLC_PARITY_BIT] == 1'b0
  ) else $error("reserved or parity bit not zero");

  window_excl_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    meas_valid && lower_threshold_a_q <= upper_threshold_q
    |=> !(below_lower_a_flag && above_upper_flag)
  ) else $error("both flags set in valid window");

  other_rd_zero_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reg_addr != CVLC_OFS_LOWER_A && reg_addr != CVLC_OFS_UPPER
    |=> reg_rdata == CVLC_UNMAPPED_RD
  ) else $error("unmapped read not zero");

endmodule // cvlc_top
`default_nettype wire

/* testbench/coil_voltage_limit_check_test.sv */
// Self-checking bench for the coil voltage limit check
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module coil_voltage_limit_check_test;
  import cvlc_pkg::*;
  logic mclk = 0, rst_b = 0, reg_wr = 0, fire = 0, mv, lo, hi;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [9:0] val = 10'h000, mcv;
  int mismatches = 0, samples_checked = 0;
  always #5 mclk = ~mclk;
  cvlc_meas_src src_u (.mclk(mclk), .fire(fire), .value(val), .meas_valid(mv),
    .measured_coil_voltage(mcv));
  cvlc_top dut_u (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_valid(mv),
    .measured_coil_voltage(mcv), .below_lower_a_flag(lo), .above_upper_flag(hi));
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk) #1 reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk) #1 reg_wr = 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge mclk) #1 reg_addr = a;
    repeat (2) @(posedge mclk);
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic meas(input logic [9:0] v, input logic el, input logic eh);
    @(posedge mclk) #1 fire = 1;
    val = v;
    @(posedge mclk) #1 fire = 0;
    @(posedge mclk) #1 `CHK({lo, hi}, {el, eh})
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst_b = 1;
    rd(CVLC_OFS_LOWER_A, 16'h0000);
    rd(CVLC_OFS_UPPER, 16'h07FE);
    rd(7'h0D, 16'h0000);
    wr(CVLC_OFS_LOWER_A, 16'hFFFF);
    rd(CVLC_OFS_LOWER_A, 16'h07FE);
    wr(CVLC_OFS_LOWER_A, 16'h0010);
    wr(7'h0D, 16'h0400);
    wr(CVLC_OFS_UPPER, 16'h0020);
    rd(CVLC_OFS_LOWER_A, 16'h0010);
    rd(CVLC_OFS_UPPER, 16'h0020);
    meas(10'h007, 1, 0);
    repeat (5) @(posedge mclk);
    #1 `CHK({lo, hi}, 2'b10)
    meas(10'h008, 0, 0);
    meas(10'h010, 0, 0);
    meas(10'h011, 0, 1);
    wr(CVLC_OFS_LOWER_A, 16'h0400);
    meas(10'h1FF, 1, 1);
    meas(10'h200, 0, 1);
    @(posedge mclk) #1 rst_b = 0;
    #1 `CHK({lo, hi}, 2'b00)
    repeat (2) @(posedge mclk);
    #1 rst_b = 1;
    rd(CVLC_OFS_LOWER_A, 16'h0000);
    rd(CVLC_OFS_UPPER, 16'h07FE);
    give_verdict();
  end
endmodule // coil_voltage_limit_check_test
`default_nettype wire

/* testbench/cvlc_meas_src.sv */
// Measurement source standing in for the averaging stage
`timescale 1ns/100ps
`default_nettype none
module cvlc_meas_src (
  input  wire logic       mclk,                  // System clock
  input  wire logic       fire,                  // Bench asks for one sample
  input  wire logic [9:0] value,                 // Averaged value to present
  output logic            meas_valid,            // One-cycle valid pulse
  output logic [9:0]      measured_coil_voltage  // Value, junk outside pulse
);
  // Inverted junk when idle exposes sampling outside the pulse
  always_ff @(posedge mclk) begin
    meas_valid            <= fire;
    measured_coil_voltage <= fire ? value : ~value;
  end
endmodule // cvlc_meas_src
`default_nettype wire
